// ===== inc/scp_pkg.sv
/*
  Package for the serial control port: register indices, field positions,
  reset values, address and timing constants.
  Assumes an I2C-style two-wire master outside and a 200 MHz core clock.
*/
// How it works
// - Answer one of two slave addresses; the choosing bit comes from the strapped select pin.
// - Last bit of first byte is direction: one read, zero write.
// - After start, shift eight bits, address then direction, MSB first.
// - On address match pull SDA low at ninth pulse; else release, idle.
// - Second byte loads pointer; pointer steps after each data byte until stop.
// - Stop out of sequence sends the port straight to idle; start sends it straight to address.
// - Invalid subaddress gets no acknowledge and the port returns idle.
// - Read past top register keeps returning top register until master NACKs.
// - Write past top register is discarded, NACKed, and port goes idle.
// - Pointer is write-only; every other register reads and writes.
// - Register zero: standard low two bits, luma next three, chroma top three.
// - Chroma select picks five low-pass cut-offs or two picture-format filters.
// - Register one holds six DAC power-down bits in its low positions.
// - Oversample bit one gives 54 MHz output; zero gives no oversampling.
// - Register two bit zero selects RGB or YUV on the DAC groups.
package scp_pkg;
  localparam logic [7:0] SCP_REG_STD_FILTER = 8'h00;
  localparam logic [7:0] SCP_REG_DAC_OVS = 8'h01;
  localparam logic [7:0] SCP_REG_OUT_CFG = 8'h02;
  localparam logic [7:0] SCP_REG_TOP = 8'h02;
  localparam logic [7:0] SCP_RST_STD_FILTER = 8'h00;
  localparam logic [7:0] SCP_RST_DAC_OVS = 8'h00;
  localparam logic [7:0] SCP_RST_OUT_CFG = 8'h00;
  // Upper five address bits; arbitrary neutral value
  localparam logic [4:0] SCP_ADDR_HIGH = 5'h15;
  localparam int SCP_STD_LSB = 0;
  localparam int SCP_LUMA_LSB = 2;
  localparam int SCP_CHROMA_LSB = 5;
  localparam int SCP_OVS_BIT = 6;
  localparam int SCP_RSVD_BIT = 7;
  localparam int SCP_RGBYUV_BIT = 0;
  localparam int SCP_PTR_TOP_BIT = 7;
  localparam int SCP_FILT_LEN = 4;
  // Strap capture waits this many edges after reset so the pin synchroniser has filled
  localparam logic [1:0] SCP_STRAP_WAIT = 2'h3;
endpackage

// ===== core/scp_filter.sv
/*
  Two-flop synchroniser followed by an all-equal stable filter.
  Assumes the input is asynchronous to CLK.
*/
`timescale 1ns/1ps
module scp_filter #(
  parameter int LEN = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic [LEN-1:0] hist;
    logic out;
  } scp_filt_t;
  scp_filt_t st, next_st;

  // Refuse history lengths the shifter cannot hold
  if (LEN < 2 || LEN > 16) begin : g_bad_len
    $error("scp_filter LEN out of range");
  end

  // Output changes only when the history is all equal, hiding short glitches
  always_comb begin
    next_st = st;
    next_st.meta = din;
    next_st.sync = st.meta;
    next_st.hist = {st.hist[LEN-2:0], st.sync};
    if (&st.hist) begin
      next_st.out = 1'b1;
    end else if (~|st.hist) begin
      next_st.out = 1'b0;
    end
  end

  // Idle bus level is high
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{meta: 1'b1, sync: 1'b1, hist: '1, out: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.out;
endmodule

// ===== core/scp_ctrl_port.sv
/*
  Two-wire slave control port with pointer and mode registers.
  Assumes the master drives SCL; SDA is open drain, resolved outside.
*/
`timescale 1ns/1ps
module scp_ctrl_port #(
  parameter int FILT_LEN = scp_pkg::SCP_FILT_LEN
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  input wire logic ADDRESS_SELECT_PIN,
  output logic [1:0] VIDEO_STANDARD_SELECT,
  output logic [2:0] LUMA_FILTER_SELECT,
  output logic [2:0] CHROMA_FILTER_SELECT,
  output logic [5:0] DAC_POWER_DOWN_BITS,
  output logic OVERSAMPLE_4X_ENABLE,
  output logic RGB_YUV_SELECT,
  output logic BUSY
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_ACK = 6'b000100,
    S_RX = 6'b001000,
    S_TX = 6'b010000,
    S_MACK = 6'b100000
  } scp_state_t;

  typedef struct packed {
    scp_state_t fsm;
    logic scl_d;
    logic sda_d;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic rd;
    logic have_ptr;
    logic ack_drive;
    logic drv_low;
    logic [7:0] ptr;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    logic strap;
    logic [1:0] strap_cnt;
    logic [1:0] ssync;
  } scp_st_t;
  scp_st_t st, next_st;

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic addr_hit;
  logic [7:0] rd_data;

  // Refuse filter lengths the history shifter cannot hold
  if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_bad_len
    $error("scp_ctrl_port FILT_LEN out of range");
  end

  scp_filter #(.LEN(FILT_LEN)) u_scl (.clk(CLK), .rst(RST), .din(SCL), .dout(scl_f));
  scp_filter #(.LEN(FILT_LEN)) u_sda (.clk(CLK), .rst(RST), .din(SDA_IN), .dout(sda_f));

  // Register read mux; beyond the top the top register is repeated
  function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] c);
    logic [7:0] v;
    v = c;
    if (idx == scp_pkg::SCP_REG_STD_FILTER) begin
      v = a;
    end else if (idx == scp_pkg::SCP_REG_DAC_OVS) begin
      v = b;
    end
    return v;
  endfunction

  // Pointer steps but saturates one past the top so reads repeat the top
  function automatic logic [7:0] ptr_step(input logic [7:0] p);
    logic [7:0] n;
    n = p;
    if (p <= scp_pkg::SCP_REG_TOP) begin
      n = p + 8'h01;
    end
    return n;
  endfunction

  // Bus events from the filtered lines
  assign scl_rise = scl_f & ~st.scl_d;
  assign scl_fall = ~scl_f & st.scl_d;
  assign start_c = scl_f & st.scl_d & st.sda_d & ~sda_f;
  assign stop_c = scl_f & st.scl_d & ~st.sda_d & sda_f;
  assign addr_hit = st.shreg[7:3] == scp_pkg::SCP_ADDR_HIGH && st.shreg[2] == 1'b0 &&
                    st.shreg[1] == st.strap;
  assign rd_data = reg_read(st.ptr, st.r0, st.r1, st.r2);

  // Port state machine; everything moves on SCL edges except start and stop
  always_comb begin
    next_st = st;
    next_st.scl_d = scl_f;
    next_st.sda_d = sda_f;
    next_st.ssync = {st.ssync[0], ADDRESS_SELECT_PIN};
    // Strap is caught once, after reset has released and the sync has filled
    // Taking it at the first edge would latch the synchroniser's reset value instead of the pin
    if (st.strap_cnt != scp_pkg::SCP_STRAP_WAIT) begin
      next_st.strap = st.ssync[1];
      next_st.strap_cnt = st.strap_cnt + 2'h1;
    end
    if (start_c) begin
      next_st.fsm = S_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.have_ptr = 1'b0;
      next_st.drv_low = 1'b0;
    end else if (stop_c) begin
      next_st.fsm = S_IDLE;
      next_st.drv_low = 1'b0;
    end else begin
      case (st.fsm)
        S_IDLE: begin
          next_st.drv_low = 1'b0;
        end
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            next_st.shreg = {st.shreg[6:0], sda_f};
            next_st.bitcnt = st.bitcnt + 4'h1;
          end
          if (scl_fall && st.bitcnt == 4'h8) begin
            next_st.bitcnt = 4'h0;
            next_st.ack_drive = 1'b0;
            if (st.fsm == S_ADDR) begin
              if (addr_hit) begin
                next_st.rd = st.shreg[0];
                next_st.ack_drive = 1'b1;
                next_st.drv_low = 1'b1;
                next_st.fsm = S_ACK;
              end else begin
                next_st.fsm = S_IDLE;
              end
            end else if (!st.have_ptr) begin
              if (st.shreg[scp_pkg::SCP_PTR_TOP_BIT] == 1'b0 && st.shreg <= scp_pkg::SCP_REG_TOP) begin
                next_st.ptr = st.shreg;
                next_st.have_ptr = 1'b1;
                next_st.ack_drive = 1'b1;
                next_st.drv_low = 1'b1;
                next_st.fsm = S_ACK;
              end else begin
                next_st.fsm = S_IDLE;
              end
            end else if (st.ptr > scp_pkg::SCP_REG_TOP) begin
              next_st.fsm = S_IDLE;
            end else begin
              if (st.ptr == scp_pkg::SCP_REG_STD_FILTER) begin
                next_st.r0 = st.shreg;
              end else if (st.ptr == scp_pkg::SCP_REG_DAC_OVS) begin
                next_st.r1 = st.shreg;
              end else begin
                next_st.r2 = st.shreg;
              end
              next_st.ptr = ptr_step(st.ptr);
              next_st.ack_drive = 1'b1;
              next_st.drv_low = 1'b1;
              next_st.fsm = S_ACK;
            end
          end
        end
        S_ACK: begin
          // Release at the end of the ninth pulse
          if (scl_fall) begin
            next_st.drv_low = 1'b0;
            next_st.bitcnt = 4'h0;
            if (st.rd) begin
              next_st.fsm = S_TX;
              next_st.shreg = rd_data;
              next_st.drv_low = ~rd_data[7];
              next_st.bitcnt = 4'h1;
            end else begin
              next_st.fsm = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (st.bitcnt == 4'h8) begin
              next_st.drv_low = 1'b0;
              next_st.ptr = ptr_step(st.ptr);
              next_st.fsm = S_MACK;
            end else begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.drv_low = ~st.shreg[6];
              next_st.bitcnt = st.bitcnt + 4'h1;
            end
          end
        end
        S_MACK: begin
          // Master acknowledge sampled on the ninth rising edge
          if (scl_rise) begin
            next_st.rd = ~sda_f;
          end
          if (scl_fall) begin
            if (st.rd) begin
              next_st.shreg = rd_data;
              next_st.drv_low = ~rd_data[7];
              next_st.bitcnt = 4'h1;
              next_st.fsm = S_TX;
            end else begin
              next_st.fsm = S_IDLE;
            end
          end
        end
        default: begin
          next_st.fsm = S_IDLE;
          next_st.drv_low = 1'b0;
        end
      endcase
    end
  end

  // All state, including registers, in one flop bank
  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '{fsm: S_IDLE, scl_d: 1'b1, sda_d: 1'b1, shreg: 8'h00, bitcnt: 4'h0, rd: 1'b0,
              have_ptr: 1'b0, ack_drive: 1'b0, drv_low: 1'b0, ptr: 8'h00,
              r0: scp_pkg::SCP_RST_STD_FILTER, r1: scp_pkg::SCP_RST_DAC_OVS,
              r2: scp_pkg::SCP_RST_OUT_CFG, strap: 1'b0, strap_cnt: 2'h0, ssync: 2'h0};
    end else begin
      st <= next_st;
    end
  end

  // Open drain: enable low only while pulling SDA down
  assign SDA_OUT = 1'b0;
  assign SDA_OE_N = ~st.drv_low;
  assign VIDEO_STANDARD_SELECT = st.r0[scp_pkg::SCP_STD_LSB +: 2];
  assign LUMA_FILTER_SELECT = st.r0[scp_pkg::SCP_LUMA_LSB +: 3];
  assign CHROMA_FILTER_SELECT = st.r0[scp_pkg::SCP_CHROMA_LSB +: 3];
  assign DAC_POWER_DOWN_BITS = st.r1[5:0];
  assign OVERSAMPLE_4X_ENABLE = st.r1[scp_pkg::SCP_OVS_BIT];
  assign RGB_YUV_SELECT = st.r2[scp_pkg::SCP_RGBYUV_BIT];
  assign BUSY = st.fsm != S_IDLE;

  // Checks
  sequence s_addr_byte_done;
    st.fsm == S_ADDR && scl_fall && st.bitcnt == 4'h8 && !start_c && !stop_c;
  endsequence

  property p_ack_on_hit;
    @(posedge CLK) disable iff (RST) s_addr_byte_done and addr_hit |=> !SDA_OE_N && st.ack_drive && st.fsm == S_ACK;
  endproperty
  a_ack_on_hit: assert property (p_ack_on_hit) else $error("no ack on address match");

  property p_idle_on_miss;
    @(posedge CLK) disable iff (RST) s_addr_byte_done and !addr_hit |=> st.fsm == S_IDLE && SDA_OE_N;
  endproperty
  a_idle_on_miss: assert property (p_idle_on_miss) else $error("mismatch not idle");

  property p_stop_idle;
    @(posedge CLK) disable iff (RST) stop_c && !start_c |=> st.fsm == S_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

  property p_start_addr;
    @(posedge CLK) disable iff (RST) start_c |=> st.fsm == S_ADDR && st.bitcnt == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_dir;
    @(posedge CLK) disable iff (RST) s_addr_byte_done and addr_hit |=> st.rd == $past(st.shreg[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");

  property p_bad_sub;
    @(posedge CLK) disable iff (RST)
      st.fsm == S_RX && !st.have_ptr && scl_fall && st.bitcnt == 4'h8 && !start_c && !stop_c &&
      st.shreg > scp_pkg::SCP_REG_TOP |=> st.fsm == S_IDLE && SDA_OE_N;
  endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("invalid subaddress acked");

  property p_over_write;
    @(posedge CLK) disable iff (RST)
      st.fsm == S_RX && st.have_ptr && st.ptr > scp_pkg::SCP_REG_TOP && scl_fall && st.bitcnt == 4'h8 &&
      !start_c && !stop_c |=> st.fsm == S_IDLE && $stable(st.r2) && SDA_OE_N;
  endproperty
  a_over_write: assert property (p_over_write) else $error("overrun write stored");

  property p_ptr_bound;
    @(posedge CLK) disable iff (RST) st.ptr <= scp_pkg::SCP_REG_TOP + 8'h01;
  endproperty
  a_ptr_bound: assert property (p_ptr_bound) else $error("pointer ran away");

  property p_ovs_map;
    @(posedge CLK) disable iff (RST) OVERSAMPLE_4X_ENABLE == st.r1[6] && DAC_POWER_DOWN_BITS == st.r1[5:0];
  endproperty
  a_ovs_map: assert property (p_ovs_map) else $error("register one map wrong");

  property p_ptr_step;
    @(posedge CLK) disable iff (RST)
      st.fsm == S_RX && st.have_ptr && st.ptr <= scp_pkg::SCP_REG_TOP && scl_fall && st.bitcnt == 4'h8 &&
      !start_c && !stop_c |=> st.ptr == $past(st.ptr) + 8'h01 && !SDA_OE_N;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step on write");
endmodule

// ===== bench/scp_bus_master.sv
/*
  Two-wire bus master model: drives SCL and pulls SDA low.
  Assumes SDA is resolved outside with a pull-up.
*/
`timescale 1ns/1ps
module scp_bus_master #(
  parameter int H = 8
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_vld,
  output logic [8:0] res
);
  // Data moves a quarter bit after SCL falls; a slave still pulling only delays the rise, not past SCL rise
  localparam int Q = H / 2;

  // Bus idles with both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_vld = 1'b0;
    res = 9'h000;
  end

  // Every change lands 1 ns after a clock edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Opens a transfer, also as a repeated start from SCL low
  task automatic start();
    sda_low = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(H);
    sda_low = 1'b1;
    hold(H);
    scl = 1'b0;
    hold(Q);
  endtask

  // Ends a transfer; SDA rises while SCL is high
  task automatic stop();
    sda_low = 1'b1;
    hold(Q);
    scl = 1'b1;
    hold(H);
    sda_low = 1'b0;
    hold(H);
  endtask

  // One bit: the line is sampled just before SCL falls
  task automatic bit_io(input logic v, output logic b);
    sda_low = !v;
    hold(Q);
    scl = 1'b1;
    hold(H);
    b = sda;
    scl = 1'b0;
    hold(H - Q);
  endtask

  // Eight bits MSB first, then the ninth; fewer bits cut a byte short
  task automatic xfer(input logic [7:0] d, input logic ack_in, input int nbits);
    logic [8:0] r;
    r = 9'h000;
    for (int i = 7; i >= 8 - nbits; i--) bit_io(d[i], r[i]);
    if (nbits == 8) begin
      bit_io(ack_in, r[8]);
      res = r;
      res_vld = 1'b1;
      hold(1);
      res_vld = 1'b0;
    end
  endtask
endmodule

// ===== bench/scp_ctrl_port_tb.sv
/*
  Self-checking bench for the serial control port.
  Assumes the bus master model and a pull-up on SDA.
*/
`timescale 1ns/1ps
module scp_ctrl_port_tb;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic strap = 1'b0;
  logic sda_oe_n, sda_out, scl, m_low, m_vld, ovs, rgb, busy;
  logic o_vld = 1'b0;
  logic [1:0] vid;
  logic [2:0] luma, chroma;
  logic [5:0] dac;
  logic [8:0] m_res;
  logic [16:0] o_val = 17'h00000;
  logic [16:0] exq[$];
  logic [15:0] lf = 16'h0907;
  logic [7:0] rg[3];
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  // Open drain: anyone pulling wins, otherwise the pull-up
  wire sda = m_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

  always #2.5 CLK = ~CLK;

  // Short filter keeps the slave's turnaround well inside an 80 ns bus bit
  scp_ctrl_port #(.FILT_LEN(2)) u_scp_ctrl_port (.CLK(CLK), .RST(RST), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDRESS_SELECT_PIN(strap), .VIDEO_STANDARD_SELECT(vid),
    .LUMA_FILTER_SELECT(luma), .CHROMA_FILTER_SELECT(chroma), .DAC_POWER_DOWN_BITS(dac),
    .OVERSAMPLE_4X_ENABLE(ovs), .RGB_YUV_SELECT(rgb), .BUSY(busy));

  scp_bus_master #(.H(8)) u_scp_bus_master (.clk(CLK), .sda(sda), .scl(scl), .sda_low(m_low),
    .res_vld(m_vld), .res(m_res));

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] ab(input logic rw);
    return {scp_pkg::SCP_ADDR_HIGH, 1'b0, strap, rw};
  endfunction

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Oldest note is matched against whichever result shows up
  always @(posedge CLK) begin
    if (m_vld) chk({8'h00, m_res}, exq.pop_front());
    if (o_vld) chk(o_val, exq.pop_front());
  end

  // Cuts a hang short well beyond the expected run
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end

  // A write byte notes its own value with the slave's ninth bit
  task automatic wb(input logic [7:0] d, input logic ack);
    exq.push_back({8'h00, ack, d});
    u_scp_bus_master.xfer(d, 1'b1, 8);
  endtask

  task automatic rb(input logic [7:0] d, input logic mack);
    exq.push_back({8'h00, mack, d});
    u_scp_bus_master.xfer(8'hFF, mack, 8);
  endtask

  // Port outputs against the modelled register file
  task automatic look(input logic bsy);
    exq.push_back({rg[0], rg[1][6:0], rg[2][0], bsy});
    o_val = {chroma, luma, vid, ovs, dac, rgb, busy};
    o_vld = 1'b1;
    @(posedge CLK);
    #1;
    o_vld = 1'b0;
  endtask

  // Strap is held still across reset so the slave latches it
  task automatic rst_to(input logic s);
    strap = s;
    RST = 1'b1;
    repeat (10) @(posedge CLK);
    #1;
    RST = 1'b0;
    rg = '{8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge CLK);
    #1;
  endtask

  task automatic test_done();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence, once per strap level
  initial begin
    logic [7:0] nv[3];
    for (int s = 0; s < 2; s++) begin
      rst_to(s[0]);
      look(1'b0);
      u_scp_bus_master.start();
      wb({scp_pkg::SCP_ADDR_HIGH, 1'b0, !strap, 1'b0}, 1'b1);
      u_scp_bus_master.stop();
      for (int i = 0; i < 3; i++) begin
        lf = step(lf);
        nv[i] = lf[7:0] & (i == 1 ? 8'h7F : 8'hFF);
      end
      u_scp_bus_master.start();
      wb(ab(1'b0), 1'b0);
      look(1'b1);
      wb(8'h00, 1'b0);
      for (int i = 0; i < 3; i++) wb(nv[i], 1'b0);
      wb(~nv[0], 1'b1);
      u_scp_bus_master.stop();
      rg = nv;
      look(1'b0);
      // Read back from register zero past the last register
      u_scp_bus_master.start();
      wb(ab(1'b0), 1'b0);
      wb(8'h00, 1'b0);
      u_scp_bus_master.start();
      wb(ab(1'b1), 1'b0);
      for (int i = 0; i < 5; i++) rb(rg[i > 2 ? 2 : i], i == 4);
      u_scp_bus_master.stop();
      for (int i = 0; i < 2; i++) begin
        u_scp_bus_master.start();
        wb(ab(1'b0), 1'b0);
        wb(i ? 8'h80 : 8'h03, 1'b1);
        u_scp_bus_master.stop();
      end
      // Single register update leaves the others alone
      lf = step(lf);
      rg[1] = {1'b0, !s[0], lf[5:0]};
      u_scp_bus_master.start();
      wb(ab(1'b0), 1'b0);
      wb(8'h01, 1'b0);
      wb(rg[1], 1'b0);
      u_scp_bus_master.stop();
      look(1'b0);
      // Stop and start in mid-byte abort cleanly
      u_scp_bus_master.start();
      wb(ab(1'b0), 1'b0);
      wb(8'h02, 1'b0);
      u_scp_bus_master.xfer(~rg[2], 1'b1, 4);
      u_scp_bus_master.stop();
      look(1'b0);
      u_scp_bus_master.start();
      wb(ab(1'b0), 1'b0);
      u_scp_bus_master.xfer(8'h00, 1'b1, 3);
      u_scp_bus_master.start();
      wb(ab(1'b0), 1'b0);
      wb(8'h02, 1'b0);
      lf = step(lf);
      rg[2] = lf[7:0];
      wb(rg[2], 1'b0);
      u_scp_bus_master.stop();
      look(1'b0);
    end
    test_done();
  end
endmodule
